// ==== rtl/urx_regs.svh ====
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define URX_PORT_STRIDE   8'h10
`define URX_CTRL_OFS      8'h00
`define URX_ADDR_OFS      8'h04
`define URX_DATA_OFS      8'h08
`define URX_STATUS_OFS    8'h20
`define URX_MASK_OFS      8'h24

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define URX_CTRL_MODE_LSB 0
`define URX_CTRL_MP_BIT   2
`define URX_CTRL_FC_BIT   3
`define URX_CTRL_DIV_LSB  16
`define URX_ADDR_SA_LSB   0
`define URX_ADDR_SM_LSB   8
`define URX_ST_DONE_BIT   0
`define URX_ST_FE_BIT     1
`define URX_ST_PER_PORT   2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define URX_DIV_RST       16'h01b1
`define URX_SA_RST        8'h00
`define URX_SM_RST        8'h00

`endif

// ==== rtl/urx_pkg.sv ====
// Purpose: types shared by the receive blocks
// Assumes: nothing
// Notes:   codes written out
package urx_pkg;

    typedef enum logic [1:0] {
        URX_IDLE  = 2'b00,
        URX_START = 2'b01,
        URX_DATA  = 2'b10,
        URX_STOP  = 2'b11
    } urx_state_t;

    typedef enum logic [1:0] {
        URX_MODE0 = 2'b00,
        URX_MODE1 = 2'b01,
        URX_MODE2 = 2'b10,
        URX_MODE3 = 2'b11
    } urx_mode_t;

endpackage : urx_pkg

// ==== rtl/urx_rx_chan.sv ====
// Purpose: one receive channel with stop check and address filter
// Assumes: rx_i synchronous to sys_clk_i, idle high
// Notes:   one bit time is div_i+1 clocks
`timescale 1ns/100ps
module urx_rx_chan
    import urx_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        rx_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        mp_en_i,
    input  wire logic        fc_en_i,
    input  wire logic [15:0] div_i,
    input  wire logic [7:0]  station_address_reg_i,
    input  wire logic [7:0]  station_address_mask_reg_i,
    output logic             done_o,
    output logic             fe_o,
    output logic [7:0]       data_o,
    output logic             bit9_o
);

    urx_state_t  state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [3:0]  bitn_reg, bitn_next;
    logic [8:0]  sh_reg, sh_next;
    logic        rxp_reg, rxp_next;
    logic        done_reg, done_next;
    logic        fe_reg, fe_next;
    logic [7:0]  data_reg, data_next;
    logic        b9_reg, b9_next;

    logic        async_m, mp_act, late, nine;
    logic [3:0]  last_bit;
    logic [8:0]  frame;
    logic        stop_v, addr_fr, given_m, bcast_m, accept;
    logic [7:0]  bc;

    // ----------------------------------------------------------------
    // frame evaluation
    // ----------------------------------------------------------------
    always_comb begin
        async_m  = (mode_i != URX_MODE0);
        mp_act   = mp_en_i && async_m;
        nine     = (mode_i == URX_MODE2) || (mode_i == URX_MODE3);
        last_bit = nine ? 4'h8 : 4'h7;
        // stop bit decides ready time when checking or mode 1 filtering
        late     = (fc_en_i && async_m)
                   || (mp_act && mode_i == URX_MODE1);
        frame    = sh_reg;
        if (state_reg == URX_DATA) begin
            frame[bitn_reg] = rx_i;
        end
        stop_v   = (state_reg == URX_STOP) ? rx_i : 1'b1;
        given_m  = ((frame[7:0] ^ station_address_reg_i) & station_address_mask_reg_i) == 8'h00;
        bc       = station_address_reg_i | station_address_mask_reg_i;
        bcast_m  = (frame[7:0] & bc) == bc;
        addr_fr  = nine ? frame[8] : stop_v;
        if (!mp_act) begin
            accept = 1'b1;
        end else if (mode_i == URX_MODE1) begin
            accept = addr_fr && (given_m || bcast_m);
        end else begin
            accept = addr_fr && (given_m || bcast_m);
        end
    end

    // ----------------------------------------------------------------
    // receive sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        bitn_next  = bitn_reg;
        sh_next    = sh_reg;
        rxp_next   = rx_i;
        done_next  = 1'b0;
        fe_next    = 1'b0;
        data_next  = data_reg;
        b9_next    = b9_reg;
        case (state_reg)
            URX_IDLE: begin
                // falling edge only, so a low stop bit is not a new start
                if (rxp_reg && !rx_i) begin
                    state_next = URX_START;
                    cnt_next   = {1'b0, div_i[15:1]};
                end
            end
            URX_START: begin
                if (cnt_reg == 16'h0000) begin
                    cnt_next   = div_i;
                    bitn_next  = 4'h0;
                    state_next = rx_i ? URX_IDLE : URX_DATA;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            URX_DATA: begin
                if (cnt_reg == 16'h0000) begin
                    sh_next   = frame;
                    cnt_next  = div_i;
                    bitn_next = bitn_reg + 4'h1;
                    if (bitn_reg == last_bit) begin
                        // stop bit is always waited out, never a start
                        state_next = URX_STOP;
                        if (!late) begin
                            done_next  = accept;
                            data_next  = frame[7:0];
                            b9_next    = nine ? frame[8] : 1'b1;
                        end
                    end
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            URX_STOP: begin
                if (cnt_reg == 16'h0000) begin
                    state_next = URX_IDLE;
                    fe_next    = fc_en_i && async_m && !rx_i;
                    done_next  = late && accept;
                    data_next  = frame[7:0];
                    b9_next    = nine ? frame[8] : rx_i;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            default: begin
                state_next = URX_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= URX_IDLE;
            cnt_reg   <= 16'h0000;
            bitn_reg  <= 4'h0;
            sh_reg    <= 9'h000;
            rxp_reg   <= 1'b1;
            done_reg  <= 1'b0;
            fe_reg    <= 1'b0;
            data_reg  <= 8'h00;
            b9_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            bitn_reg  <= bitn_next;
            sh_reg    <= sh_next;
            rxp_reg   <= rxp_next;
            done_reg  <= done_next;
            fe_reg    <= fe_next;
            data_reg  <= data_next;
            b9_reg    <= b9_next;
        end
    end

    assign done_o = done_reg;
    assign fe_o   = fe_reg;
    assign data_o = data_reg;
    assign bit9_o = b9_reg;

endmodule : urx_rx_chan

// ==== rtl/urx_top.sv ====
// Purpose: two receive ports with stop check, address recognition,
//          AHB-Lite register slave and a masked interrupt
// Assumes: single word transfers, inputs synchronous to sys_clk_i
// Notes:   reads take one wait state, writes none
//
// What this block does
// - each port receives in modes zero to three at its own bit rate
// - both ports carry identical checking, own enables, flags, addresses
// - stop-bit checking runs only in modes one to three and only when the port's check enable is set
// - with checking on, a bad stop bit sets the frame error flag
// - frame error flag stays until software clears it or reset
// - with checking on, receive done rises at the stop bit
// - address recognition runs whenever multiprocessor enable is set in modes one to three
// - address frames raise receive done only on given or broadcast match
// - mode 1 filtering uses the stop bit as ninth bit, must be valid
// - in mode 0 multiprocessor enable has no effect
// - given address compares only bits where the mask is one
// - broadcast address is address or mask, zeros are don't care
// - address and mask reset to zero, so any address is accepted
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`include "urx_regs.svh"
module urx_top
    import urx_pkg::*;
#(
    parameter int NPORT = 2
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [1:0]  rx_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // bus slave state
    // ----------------------------------------------------------------
    logic        wr_pend_reg, wr_pend_next;
    logic        rd_pend_reg, rd_pend_next;
    logic [7:0]  ad_reg, ad_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        hready_reg, hready_next;
    logic        irq_reg, irq_next;
    logic        take;

    // ----------------------------------------------------------------
    // per port registers
    // ----------------------------------------------------------------
    logic [1:0]  mode_reg [NPORT];
    logic [1:0]  mode_next [NPORT];
    logic        mp_reg [NPORT];
    logic        mp_next [NPORT];
    logic        fc_reg [NPORT];
    logic        fc_next [NPORT];
    logic [15:0] div_reg [NPORT];
    logic [15:0] div_next [NPORT];
    logic [7:0]  sa_reg [NPORT];
    logic [7:0]  sa_next [NPORT];
    logic [7:0]  sm_reg [NPORT];
    logic [7:0]  sm_next [NPORT];
    logic [3:0]  status_reg, status_next;
    logic [3:0]  mask_reg, mask_next;

    logic        done_w [NPORT];
    logic        fe_w [NPORT];
    logic [7:0]  data_w [NPORT];
    logic        b9_w [NPORT];
    logic [3:0]  ev_set;

    // ----------------------------------------------------------------
    // receive channels
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            urx_rx_chan u_chan (
                .sys_clk_i (sys_clk_i),
                .rst_i     (rst_i),
                .rx_i      (rx_i[g]),
                .mode_i    (mode_reg[g]),
                .mp_en_i   (mp_reg[g]),
                .fc_en_i   (fc_reg[g]),
                .div_i     (div_reg[g]),
                .station_address_reg_i   (sa_reg[g]),
                .station_address_mask_reg_i   (sm_reg[g]),
                .done_o    (done_w[g]),
                .fe_o      (fe_w[g]),
                .data_o    (data_w[g]),
                .bit9_o    (b9_w[g])
            );
            assign ev_set[`URX_ST_PER_PORT*g + `URX_ST_DONE_BIT] = done_w[g];
            assign ev_set[`URX_ST_PER_PORT*g + `URX_ST_FE_BIT]   = fe_w[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // register file and bus
    // ----------------------------------------------------------------
    always_comb begin
        take         = hsel_i && htrans_i[1] && hready_i;
        wr_pend_next = take && hwrite_i;
        rd_pend_next = take && !hwrite_i;
        ad_next      = take ? haddr_i[7:0] : ad_reg;
        // one wait state lets a read see the write just before it
        hready_next  = !(take && !hwrite_i);
        hrdata_next  = hrdata_reg;
        for (int p = 0; p < NPORT; p++) begin
            mode_next[p] = mode_reg[p];
            mp_next[p]   = mp_reg[p];
            fc_next[p]   = fc_reg[p];
            div_next[p]  = div_reg[p];
            sa_next[p]   = sa_reg[p];
            sm_next[p]   = sm_reg[p];
        end
        mask_next   = mask_reg;
        status_next = status_reg;
        if (wr_pend_reg) begin
            if (ad_reg == `URX_STATUS_OFS) begin
                status_next = status_reg & ~hwdata_i[3:0];
            end else if (ad_reg == `URX_MASK_OFS) begin
                mask_next = hwdata_i[3:0];
            end else begin
                for (int p = 0; p < NPORT; p++) begin
                    if (ad_reg == 8'(p) * `URX_PORT_STRIDE
                                  + `URX_CTRL_OFS) begin
                        mode_next[p] = hwdata_i[`URX_CTRL_MODE_LSB +: 2];
                        mp_next[p]   = hwdata_i[`URX_CTRL_MP_BIT];
                        fc_next[p]   = hwdata_i[`URX_CTRL_FC_BIT];
                        div_next[p]  = hwdata_i[`URX_CTRL_DIV_LSB +: 16];
                    end else if (ad_reg == 8'(p) * `URX_PORT_STRIDE
                                         + `URX_ADDR_OFS) begin
                        sa_next[p] = hwdata_i[`URX_ADDR_SA_LSB +: 8];
                        sm_next[p] = hwdata_i[`URX_ADDR_SM_LSB +: 8];
                    end
                end
            end
        end
        // hardware set wins over a software clear in the same cycle
        status_next = status_next | ev_set;
        if (rd_pend_reg && !hready_reg) begin
            hrdata_next = 32'h0000_0000;
            if (ad_reg == `URX_STATUS_OFS) begin
                hrdata_next[3:0] = status_reg;
            end else if (ad_reg == `URX_MASK_OFS) begin
                hrdata_next[3:0] = mask_reg;
            end else begin
                for (int p = 0; p < NPORT; p++) begin
                    if (ad_reg == 8'(p) * `URX_PORT_STRIDE
                                  + `URX_CTRL_OFS) begin
                        hrdata_next[`URX_CTRL_MODE_LSB +: 2] = mode_reg[p];
                        hrdata_next[`URX_CTRL_MP_BIT]       = mp_reg[p];
                        hrdata_next[`URX_CTRL_FC_BIT]       = fc_reg[p];
                        hrdata_next[`URX_CTRL_DIV_LSB +: 16] = div_reg[p];
                    end else if (ad_reg == 8'(p) * `URX_PORT_STRIDE
                                         + `URX_ADDR_OFS) begin
                        hrdata_next[`URX_ADDR_SA_LSB +: 8] = sa_reg[p];
                        hrdata_next[`URX_ADDR_SM_LSB +: 8] = sm_reg[p];
                    end else if (ad_reg == 8'(p) * `URX_PORT_STRIDE
                                         + `URX_DATA_OFS) begin
                        hrdata_next[7:0] = data_w[p];
                        hrdata_next[8]   = b9_w[p];
                    end
                end
            end
        end
        irq_next = |(status_next & mask_next);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            ad_reg      <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
            hready_reg  <= 1'b1;
            irq_reg     <= 1'b0;
            status_reg  <= 4'h0;
            mask_reg    <= 4'h0;
            for (int p = 0; p < NPORT; p++) begin
                mode_reg[p] <= URX_MODE0;
                mp_reg[p]   <= 1'b0;
                fc_reg[p]   <= 1'b0;
                div_reg[p]  <= `URX_DIV_RST;
                sa_reg[p]   <= `URX_SA_RST;
                sm_reg[p]   <= `URX_SM_RST;
            end
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            ad_reg      <= ad_next;
            hrdata_reg  <= hrdata_next;
            hready_reg  <= hready_next;
            irq_reg     <= irq_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            for (int p = 0; p < NPORT; p++) begin
                mode_reg[p] <= mode_next[p];
                mp_reg[p]   <= mp_next[p];
                fc_reg[p]   <= fc_next[p];
                div_reg[p]  <= div_next[p];
                sa_reg[p]   <= sa_next[p];
                sm_reg[p]   <= sm_next[p];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = hready_reg;
    assign hresp_o     = 1'b0;
    assign irq_o       = irq_reg;

endmodule : urx_top

// ==== testbench/urx_line_model.sv ====
// Purpose: serial stations driving the two receive lines
// Assumes: lines idle high, bit time in clocks given per frame
// Notes:   a zero stop bit is the only fault, sent only on request
`timescale 1ns/100ps
module urx_line_model (
    input  wire logic       sys_clk_i,
    output logic      [1:0] rx_o
);
    // ------------------------------------------------------------
    // frame sender
    // ------------------------------------------------------------
    initial rx_o = 2'b11;

    task automatic send(input int p, input logic [7:0] b,
                        input logic nine, input logic b9,
                        input logic st, input int bt);
        logic [10:0] f;
        f = nine ? {st, b9, b, 1'b0} : {2'b11, st, b, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(posedge sys_clk_i);
            rx_o[p] <= f[i];
            repeat (bt - 1) @(posedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        rx_o[p] <= 1'b1;
        // idle gap lets the receiver finish before the next start
        repeat (2 * bt) @(posedge sys_clk_i);
    endtask : send
endmodule : urx_line_model

// ==== testbench/urx_top_sva.sv ====
// Purpose: bus and interrupt checks at the receive block's ports
// Assumes: single word transfers, hready tied to hreadyout
// Notes:   serial side results are judged by the bench
`timescale 1ns/100ps
module urx_top_chk (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        irq_o
);
    logic take;
    logic wr_q_reg;
    logic wr_q_next;
    logic any_wr_reg;
    logic any_wr_next;

    assign take = hsel_i && htrans_i[1] && hready_i;

    always_comb begin
        wr_q_next   = take && hwrite_i;
        any_wr_next = any_wr_reg || wr_q_next;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q_reg   <= 1'b0;
            any_wr_reg <= 1'b0;
        end else begin
            wr_q_reg   <= wr_q_next;
            any_wr_reg <= any_wr_next;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_rd_wait: assert property (take && !hwrite_i |=>
        !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
    chk_wr_zero: assert property (take && hwrite_i |=>
        hreadyout_o) else $error("write stalled");
    chk_wait_one: assert property (!hreadyout_o |=>
        hreadyout_o) else $error("wait longer than one");
    chk_resp_okay: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    chk_rdata_hold: assert property ($changed(hrdata_o) |->
        $rose(hreadyout_o)) else $error("read data moved");
    chk_unmap_zero: assert property (take && !hwrite_i &&
        haddr_i[7:0] >= 8'h28 |-> ##2 hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    // irq may only drop after software wrote status or mask
    chk_irq_clear: assert property ($fell(irq_o) |->
        $past(wr_q_reg) || $past(wr_q_reg, 2))
        else $error("irq dropped without write");
    chk_irq_quiet: assert property (!any_wr_reg |-> !irq_o)
        else $error("irq with mask at reset");

    cover property (take && !hwrite_i);
    cover property ($rose(irq_o));
    cover property ($fell(irq_o));
endmodule : urx_top_chk

bind urx_top urx_top_chk u_chk (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .hsel_i     (hsel_i),
    .haddr_i    (haddr_i),
    .htrans_i   (htrans_i),
    .hwrite_i   (hwrite_i),
    .hready_i   (hready_i),
    .hrdata_o   (hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o    (hresp_o),
    .irq_o      (irq_o)
);

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the two-port receive block
// Assumes: small divisor for a short bit time, fixed seed
// Notes:   expectations come from the bench's own functions
`timescale 1ns/100ps
`include "urx_regs.svh"
module tb;
    localparam int D  = 7;
    localparam int BT = D + 1;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  rx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #10 sys_clk = ~sys_clk;

    urx_top #(.NPORT(2)) u_dut (.sys_clk_i(sys_clk), .rst_i(rst),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .rx_i(rx), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .irq_o(irq));
    urx_line_model u_line (.sys_clk_i(sys_clk), .rx_o(rx));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) check("bus ready", 32'h0, 32'h1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, $urandom(), d);
    endtask : rd

    function automatic logic [7:0] pa(input int p, input logic [7:0] o);
        return o + 8'(p) * `URX_PORT_STRIDE;
    endfunction : pa

    function automatic logic exp_done(input logic [1:0] m, input logic mp,
        input logic [7:0] sa, input logic [7:0] sm, input logic [7:0] b,
        input logic b9, input logic st);
        logic hit;
        hit = (((b ^ sa) & sm) == 8'h0)
              || ((b & (sa | sm)) == (sa | sm));
        if (m == 2'd0 || !mp) return 1'b1;
        return hit && (m == 2'd1 ? st : b9);
    endfunction : exp_done

    task automatic frame(input int p, input logic [1:0] m, input logic mp,
        input logic fc, input logic [7:0] sa, input logic [7:0] sm,
        input logic [7:0] b, input logic b9, input logic st);
        logic [31:0] s;
        logic [31:0] d;
        logic        ed;
        wr(pa(p, `URX_CTRL_OFS), {16'(D), 12'h0, fc, mp, m});
        wr(pa(p, `URX_ADDR_OFS), {16'h0, sm, sa});
        wr(`URX_STATUS_OFS, 32'hf);
        u_line.send(p, b, m[1], b9, st, BT);
        rd(`URX_STATUS_OFS, s);
        ed = exp_done(m, mp, sa, sm, b, b9, st);
        check("done", 32'(s[2*p]), 32'(ed));
        check("fe", 32'(s[2*p+1]), 32'(fc && m != 2'd0 && !st));
        rd(pa(p, `URX_DATA_OFS), d);
        check("data", 32'(d[8:0]), 32'({(m[1] ? b9 : st), b}));
    endtask : frame

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge sys_clk);
        check("watchdog", 32'h0, 32'h1);
        report_and_stop();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] w;
        logic [7:0]  sa;
        logic [7:0]  sm;
        logic [7:0]  b;
        logic [1:0]  m;
        logic        mp;
        int          n;
        int          tl [2];
        void'($urandom(94));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(`URX_CTRL_OFS, v);
        check("ctrl reset", v, {`URX_DIV_RST, 16'h0});
        for (int p = 0; p < 2; p++) begin
            rd(pa(p, `URX_ADDR_OFS), v);
            check("addr reset", v, 32'h0);
        end
        wr(8'h30, $urandom());
        rd(8'h30, v);
        check("unmapped", v, 32'h0);
        w = $urandom();
        wr(pa(1, `URX_ADDR_OFS), w);
        rd(pa(1, `URX_ADDR_OFS), v);
        check("addr rw", v, {16'h0, w[15:0]});
        $display("test registers done");
        frame(0, 2'd3, 1'b1, 1'b0, 8'h00, 8'h00, 8'h5a, 1'b1, 1'b1);
        frame(0, 2'd1, 1'b0, 1'b1, 8'h00, 8'h00, 8'ha5, 1'b0, 1'b0);
        u_line.send(0, 8'h3c, 1'b0, 1'b0, 1'b1, BT);
        rd(`URX_STATUS_OFS, v);
        check("fe sticky", 32'(v[1]), 32'h1);
        wr(`URX_STATUS_OFS, 32'h2);
        rd(`URX_STATUS_OFS, v);
        check("fe clear", 32'(v[1]), 32'h0);
        frame(1, 2'd2, 1'b0, 1'b0, 8'h00, 8'h00, 8'h0f, 1'b1, 1'b0);
        $display("test frame error done");
        wr(`URX_MASK_OFS, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(`URX_CTRL_OFS, {16'(D), 12'h0, k[0], 1'b0, 2'd1});
            wr(`URX_STATUS_OFS, 32'hf);
            fork
                u_line.send(0, 8'h81, 1'b0, 1'b0, 1'b1, BT);
                begin
                    n = 0;
                    do begin
                        @(posedge sys_clk);
                        n++;
                    end while (irq !== 1'b1 && n < 300);
                end
            join
            tl[k] = n;
        end
        check("done late", 32'(tl[1] - tl[0]), 32'(BT));
        wr(`URX_STATUS_OFS, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq cleared", 32'(irq), 32'h0);
        wr(`URX_MASK_OFS, 32'h0);
        frame(0, 2'd1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h11, 1'b0, 1'b1);
        check("irq masked", 32'(irq), 32'h0);
        wr(`URX_MASK_OFS, 32'h1);
        repeat (2) @(posedge sys_clk);
        check("irq unmasked", 32'(irq), 32'h1);
        $display("test interrupt done");
        for (int i = 0; i < 24; i++) begin
            m  = 2'($urandom());
            mp = 1'($urandom());
            sa = 8'($urandom());
            sm = 8'($urandom());
            b  = 8'($urandom());
            if (i % 4 == 0) begin
                sm = 8'hff;
                b  = sa;
            end
            if (i % 4 == 1) b = 8'hff;
            if (i % 4 == 2) b = sa ^ 8'h01;
            frame(i % 2, m, mp, 1'($urandom()), sa, sm, b, 1'($urandom()),
                  (m == 2'd1 || !mp) ? 1'($urandom()) : 1'b1);
        end
        $display("test random frames done");
        report_and_stop();
    end
endmodule : tb
